// ==== verilog/tki_idle_control.sv ====
// touch key idle control: power state, reference hold and key status readout
// assumes an outside framing front end that turns serial transfers into
// address, write and read strobes, and an analog front end that reports
// per-channel detection when asked to sample
// and a single clock with an active high asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module tki_idle_control #(
	parameter int MS_CYCLES = tki_pkg::MS_CYCLES,
	parameter int IDLE_ENTRY_MS = tki_pkg::IDLE_ENTRY_MS,
	parameter int NORMAL_SAMPLE_MS = tki_pkg::NORMAL_SAMPLE_MS,
	parameter int HALF_T_MS = tki_pkg::HALF_T_MS
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// register access from the serial framing logic
	input wire logic REG_ADDR_SET,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_RD_NEXT,
	output logic [7:0] REG_RDATA,
	// analog front end
	input wire logic [tki_pkg::NUM_KEYS-1:0] KEY_DETECT,
	output logic SAMPLE,
	output logic CAL_RUN,
	output logic IDLE,
	// open-drain key alert
	output logic ALERT_O,
	output logic ALERT_OE
);

	localparam int MSW = $clog2(MS_CYCLES + 1);
	localparam int INW = $clog2(IDLE_ENTRY_MS + 1);
	localparam int SPW = 16;

	tki_pkg::tki_ctrl_s ctrl_r;
	tki_pkg::tki_state_e state_r;
	logic [7:0] ptr_r;
	logic [MSW-1:0] div_r;
	logic ms_tick;
	logic [INW-1:0] quiet_r;
	logic [SPW-1:0] spc_r;
	logic [SPW-1:0] spc_target;
	logic spc_done;
	logic [tki_pkg::NUM_KEYS-1:0] key_state_bit_r;
	logic touched;
	logic touch_seen;
	logic idle_go;
	logic idle_no_sample;
	logic quiet_clr;
	logic [7:0] rdata_nxt;
	logic any_touch;
	logic [7:0] key_state_low;
	logic [7:0] key_state_high;

	// control register, write-only
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_r <= tki_pkg::CTRL_RESET;
		end else if (REG_WR && ptr_r == tki_pkg::ADDR_CTRL) begin
			ctrl_r <= REG_WDATA;
		end
	end

	// read pointer: set by the address byte, advances after each data byte
	// writes advance it too, so a burst starting at 02H moves on to 03H, not to the status bytes at 08H
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ptr_r <= tki_pkg::ADDR_READ_DEFAULT;
		end else if (REG_ADDR_SET) begin
			ptr_r <= REG_ADDR;
		end else if (REG_WR || REG_RD_NEXT) begin
			ptr_r <= ptr_r + 8'h01;
		end
	end

	// millisecond enable; every slower rate counts these
	// one free divider, so nothing here needs a second clock domain
	assign ms_tick = (div_r == MSW'(MS_CYCLES - 1));
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			div_r <= '0;
		end else if (ms_tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + MSW'(1);
		end
	end

	// sample spacing: normal rate, or (2c-1) half periods while idle
	always_comb begin
		spc_target = SPW'(NORMAL_SAMPLE_MS);
		if (state_r == tki_pkg::ST_IDLE) begin
			spc_target = SPW'((2 * int'(ctrl_r.interval) - 1) * HALF_T_MS);
		end
	end

	// code 0 in idle: no sample at all until the host picks another code
	assign idle_no_sample = (state_r == tki_pkg::ST_IDLE) && (ctrl_r.interval == 3'h0);
	assign spc_done = ms_tick && (spc_r + SPW'(1) >= spc_target) && !idle_no_sample;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			spc_r <= '0;
		end else if (spc_done) begin
			spc_r <= '0;
		end else if (ms_tick && spc_r != {SPW{1'b1}}) begin
			spc_r <= spc_r + SPW'(1);
		end
	end

	assign SAMPLE = spc_done;
	assign touched = |KEY_DETECT;
	// a sample that finds a finger: wakes from idle, restarts the quiet timer
	assign touch_seen = spc_done && touched;

	// status bits are inverted detection, one per channel
	// held between samples: the front end answer is only valid at the sample instant
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			key_state_bit_r <= '1;
		end else if (spc_done) begin
			key_state_bit_r <= ~KEY_DETECT;
		end
	end

	assign any_touch = ~&key_state_bit_r;

	// timer runs only in normal state; a wake-up always gets a full quiet period
	assign quiet_clr = (state_r == tki_pkg::ST_IDLE) || touch_seen;

	// inactivity time since the last touched sample
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			quiet_r <= '0;
		end else if (quiet_clr) begin
			quiet_r <= '0;
		end else if (ms_tick && quiet_r != INW'(IDLE_ENTRY_MS)) begin
			quiet_r <= quiet_r + INW'(1);
		end
	end

	// idle entry never on a touched sample, so a finger seen at the entry edge wins
	always_comb begin
		idle_go = 1'b0;
		if (!any_touch && !touch_seen) begin
			if (ctrl_r.idle_now) begin
				idle_go = 1'b1;
			end else if (quiet_r == INW'(IDLE_ENTRY_MS)) begin
				idle_go = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_r <= tki_pkg::ST_NORMAL;
		end else begin
			case (state_r)
				tki_pkg::ST_NORMAL: begin
					if (idle_go) begin
						state_r <= tki_pkg::ST_IDLE;
					end
				end
				tki_pkg::ST_IDLE: begin
					if (touch_seen) begin
						state_r <= tki_pkg::ST_NORMAL;
					end
				end
				default: begin
					state_r <= tki_pkg::ST_NORMAL;
				end
			endcase
		end
	end

	assign IDLE = (state_r == tki_pkg::ST_IDLE);
	// reference tracking pauses only on request, not in idle
	assign CAL_RUN = !ctrl_r.hold;

	// open-drain: drive low only while a key is seen
	assign ALERT_O = 1'b0;
	assign ALERT_OE = any_touch;

	// read bytes built per channel; unused bits read zero
	// the bytes are wired, not stored: a read always shows the latest sample
	genvar g;
	generate
		for (g = 0; g < tki_pkg::NUM_KEYS; g++) begin : g_map
			if (g < tki_pkg::KEY_LO_CHANNELS) begin : g_lo
				assign key_state_low[tki_pkg::KEY_LO_CH0_BIT - g] = key_state_bit_r[g];
			end else begin : g_hi
				assign key_state_high[tki_pkg::KEY_HI_CH5_BIT - (g - tki_pkg::KEY_LO_CHANNELS)] = key_state_bit_r[g];
			end
		end
	endgenerate
	assign key_state_low[7:6] = 2'h0;
	assign key_state_low[0] = 1'b0;
	assign key_state_high[3:0] = 4'h0;

	// byte at the pointer; the control register is write-only and reads zero
	always_comb begin
		rdata_nxt = 8'h00;
		case (ptr_r)
			tki_pkg::ADDR_KEY_LO: rdata_nxt = key_state_low;
			tki_pkg::ADDR_KEY_HI: rdata_nxt = key_state_high;
			tki_pkg::ADDR_CTRL: rdata_nxt = 8'h00;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// read data from flops, follows the pointer one cycle later
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			REG_RDATA <= 8'h00;
		end else begin
			REG_RDATA <= rdata_nxt;
		end
	end

endmodule // tki_idle_control
`default_nettype wire

// ==== verilog/tki_pkg.sv ====
// constants, field layouts and types of the touch key idle control block
// assumes a 100 MHz core clock and a serial framing front end outside this block
// Notes on behaviour
// - idle_immediately set: idle as soon as untouched
// - otherwise idle after 75 s without touch
// - hold set freezes reference recalculation, else continuous
// - nine status bits, one per channel
// - status bit zero when touched, one otherwise
// - control register 02H: bit4 immediate, bit3 hold
// - idle sample interval code: 0 never, (c-0.5)T
// - open-drain alert low while any key touched
// - read pointer defaults to 08H after reset
package tki_pkg;

	localparam int CLK_MHZ = 100;
	localparam int MS_CYCLES = CLK_MHZ * 1000;
	localparam int NORMAL_SAMPLE_MS = 13;
	localparam int IDLE_ENTRY_S = 75;
	localparam int IDLE_ENTRY_MS = IDLE_ENTRY_S * 1000;
	localparam int IDLE_T_MS = 120;
	localparam int HALF_T_MS = IDLE_T_MS / 2;

	localparam int NUM_KEYS = 9;

	localparam logic [7:0] ADDR_CTRL = 8'h02;
	localparam logic [7:0] ADDR_KEY_LO = 8'h08;
	localparam logic [7:0] ADDR_KEY_HI = 8'h09;
	localparam logic [7:0] ADDR_READ_DEFAULT = ADDR_KEY_LO;

	localparam int CTRL_INTERVAL_LSB = 5;
	localparam int CTRL_IDLE_NOW_BIT = 4;
	localparam int CTRL_HOLD_BIT = 3;
	localparam logic [7:0] CTRL_RESET = 8'h83;

	// channel 0 sits at bit 5 of the low byte, channel 5 at bit 7 of the high byte
	localparam int KEY_LO_CH0_BIT = 5;
	localparam int KEY_LO_CHANNELS = 5;
	localparam int KEY_HI_CH5_BIT = 7;

	typedef struct packed {
		logic [2:0] interval;
		logic idle_now;
		logic hold;
		logic [2:0] other;
	} tki_ctrl_s;

	typedef enum logic {
		ST_NORMAL,
		ST_IDLE
	} tki_state_e;

endpackage

// ==== tb/tki_props.sv ====
// checker on the ports of the touch key idle control block
// assumes binding to tki_idle_control, one clock domain
`timescale 1ns/1ps
`default_nettype none
module tki_props (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// watched signals
	input wire logic REG_WR,
	input wire logic [tki_pkg::NUM_KEYS-1:0] KEY_DETECT,
	input wire logic SAMPLE,
	input wire logic CAL_RUN,
	input wire logic IDLE,
	input wire logic ALERT_O,
	input wire logic ALERT_OE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_touch;
		SAMPLE && |KEY_DETECT;
	endsequence
	a_alert_data_low: assert property (ALERT_O == 1'b0) else $error("alert data not low");
	a_alert_from_keys: assert property (SAMPLE |=> ALERT_OE == |$past(KEY_DETECT)) else $error("alert wrong");
	a_alert_on_sample: assert property ($changed(ALERT_OE) |-> $past(SAMPLE)) else $error("alert moved");
	a_idle_exit_touch: assert property (IDLE ##0 s_touch |=> !IDLE) else $error("idle kept");
	a_idle_holds: assert property (IDLE && !SAMPLE |=> IDLE) else $error("idle lost");
	a_no_idle_touched: assert property (!IDLE && ALERT_OE && !SAMPLE |=> !IDLE) else $error("idle on touch");
	a_sample_one_cycle: assert property (SAMPLE |=> !SAMPLE) else $error("sample too long");
	a_cal_by_write: assert property ($changed(CAL_RUN) |-> $past(REG_WR)) else $error("cal moved");
endmodule // tki_props
bind tki_idle_control tki_props i_props (.CLK(CLK), .RST(RST), .REG_WR(REG_WR), .KEY_DETECT(KEY_DETECT),
	.SAMPLE(SAMPLE), .CAL_RUN(CAL_RUN), .IDLE(IDLE), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE));
`default_nettype wire

// ==== tb/tki_front_model.sv ====
// front end model: detection handed over at sample instants
// assumes the bench sets the touch pattern
`timescale 1ns/1ps
`default_nettype none
module tki_front_model (
	// sample request
	input wire logic SAMPLE,
	// touch pattern and answer
	input wire logic [tki_pkg::NUM_KEYS-1:0] touch,
	output logic [tki_pkg::NUM_KEYS-1:0] KEY_DETECT
);
	// junk outside the sample instant, never the last answer
	assign KEY_DETECT = SAMPLE ? touch : ~touch;
endmodule // tki_front_model
`default_nettype wire

// ==== tb/tki_idle_control_bench.sv ====
// self-checking bench of the touch key idle control block
// assumes shortened timing parameters
`timescale 1ns/1ps
`default_nettype none
module tki_idle_control_bench;
	logic CLK = 1'b0, RST = 1'b1, set = 1'b0, wr = 1'b0, nxt = 1'b0, SAMPLE, CAL_RUN, IDLE, ALERT_O, ALERT_OE;
	logic [7:0] addr = 8'h00, wdata = 8'h00, REG_RDATA;
	logic [8:0] touch = 9'h000, KEY_DETECT;
	int fail_count = 0, checked = 0;
	tki_idle_control #(.MS_CYCLES(10), .IDLE_ENTRY_MS(20), .NORMAL_SAMPLE_MS(2), .HALF_T_MS(3)) i_dut (
		.CLK(CLK), .RST(RST), .REG_ADDR_SET(set), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
		.REG_RD_NEXT(nxt), .REG_RDATA(REG_RDATA), .KEY_DETECT(KEY_DETECT), .SAMPLE(SAMPLE),
		.CAL_RUN(CAL_RUN), .IDLE(IDLE), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE));
	tki_front_model i_model (.SAMPLE(SAMPLE), .touch(touch), .KEY_DETECT(KEY_DETECT));
	initial begin
		forever #5 CLK = ~CLK;
	end
	task automatic close_out;
		if (fail_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic pick(input int sel);
		return (sel == 0) ? SAMPLE : IDLE;
	endfunction
	task automatic wt(input int sel);
		for (int i = 0; i < 400 && pick(sel) !== 1'b1; i++) begin
			@(posedge CLK);
			#1;
		end
		if (pick(sel) !== 1'b1) begin
			fail_count++;
			$display("Error %0t: wait timed out", $time);
			close_out();
		end else begin
			@(posedge CLK);
			#1;
		end
	endtask
	task automatic gap(input logic [7:0] exp);
		logic [7:0] n;
		n = 8'h01;
		wt(0);
		while (n < 8'hC8 && SAMPLE !== 1'b1) begin
			@(posedge CLK);
			#1;
			n++;
		end
		if (SAMPLE !== 1'b1) begin
			fail_count++;
			$display("Error %0t: sample gap timed out", $time);
			close_out();
		end else begin
			chk(exp, n);
		end
	endtask
	task automatic rd_next(input logic [7:0] exp);
		@(posedge CLK);
		nxt <= 1'b1;
		@(posedge CLK);
		nxt <= 1'b0;
		repeat (2) @(posedge CLK);
		#1 chk(exp, REG_RDATA);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge CLK);
		set <= 1;
		addr <= a;
		@(posedge CLK);
		set <= 0;
		repeat (2) @(posedge CLK);
		#1 chk(exp, REG_RDATA);
	endtask
	task automatic wrt(input logic [7:0] d);
		@(posedge CLK);
		set <= 1;
		addr <= 8'h02;
		@(posedge CLK);
		set <= 0;
		wr <= 1;
		wdata <= d;
		@(posedge CLK);
		wr <= 0;
		repeat (2) @(posedge CLK);
		#1;
	endtask
	initial begin
		int n;
		n = 0;
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		repeat (2) @(posedge CLK);
		#1 chk(8'h3E, REG_RDATA);
		chk(8'h01, {7'h00, CAL_RUN});
		rd_next(8'hF0);
		touch <= 9'h101;
		wt(0);
		chk(8'h01, {7'h00, ALERT_OE});
		rd(8'h08, 8'h1E);
		rd_next(8'hE0);
		rd(8'h09, 8'hE0);
		rd(8'h02, 8'h00);
		wrt(8'h88);
		chk(8'h00, {7'h00, CAL_RUN});
		touch <= 9'h000;
		wrt(8'h80);
		chk(8'h01, {7'h00, CAL_RUN});
		wt(0);
		chk(8'h00, {7'h00, ALERT_OE});
		chk(8'h00, {7'h00, IDLE});
		wt(1);
		touch <= 9'h010;
		wt(0);
		chk(8'h00, {7'h00, IDLE});
		rd(8'h08, 8'h3C);
		touch <= 9'h000;
		wt(0);
		wrt(8'h90);
		chk(8'h01, {7'h00, IDLE});
		wrt(8'h30);
		gap(8'h1E);
		wrt(8'h10);
		repeat (200) begin
			@(posedge CLK);
			#1;
			if (SAMPLE !== 1'b0) n++;
		end
		chk(8'h00, 8'(n));
		chk(8'h01, {7'h00, IDLE});
		close_out();
	end
endmodule // tki_idle_control_bench
`default_nettype wire
